// ==== src/slm_consts.svh ====
// constants for the service life maintenance monitor
`ifndef SLM_CONSTS_SVH
`define SLM_CONSTS_SVH
`define SLM_CLK_HZ          50000000
`define SLM_LIFE_FULL       14'd10000
`define SLM_LIFE_THRESH     14'd1000
`define SLM_ENV_LIMIT       16'd100
`define SLM_STEP_FAN        14'd1
`define SLM_STEP_CAP        14'd1
`define SLM_STEP_INRUSH     14'd1
`define SLM_STEP_DB         14'd1
`define SLM_RELAY_OPS_LIMIT 16'd30000
`define SLM_RELAY_OPS_PER   2'd3
`define SLM_WARN_CODE       12'h9b0
`define SLM_RELAY_ALM_CODE  12'h232
`define SLM_TRACE_PERIOD_NS 1000
`define SLM_TRACE_CYC       (`SLM_TRACE_PERIOD_NS / (1000000000 / `SLM_CLK_HZ))
`define SLM_POWERON_US      1000
`define SLM_POWERON_CYC     (`SLM_POWERON_US * (`SLM_CLK_HZ / 1000000))
`define SLM_TRACE_DEPTH     16
`define SLM_TRACE_POST      5'd8
`define SLM_ADR_CTRL        8'h00
`define SLM_ADR_CMD         8'h04
`define SLM_ADR_STATUS      8'h08
`define SLM_ADR_MASK        8'h0c
`define SLM_ADR_MON_FIRST   8'h10
`define SLM_ADR_MON_LAST    8'h28
`define SLM_ADR_RELAY_OPS   8'h2c
`define SLM_ADR_WARN        8'h30
`define SLM_ADR_TRACE_IDX   8'h34
`define SLM_ADR_TRACE_STAT  8'h38
`define SLM_ADR_TRACE_BASE  8'h40
`define SLM_ADR_TRACE_BITS  8'h5c
`define SLM_CTRL_WARN_EN    0
`define SLM_CTRL_RELAY_DIS  1
`define SLM_CTRL_PM_ALLOC   2
`define SLM_CTRL_BRAKE_CTL  3
`define SLM_CMD_RESTART     0
`define SLM_CMD_TRACE_REARM 1
`define SLM_ST_WARN         0
`define SLM_ST_RELAY_ALM    1
`define SLM_ST_TRACE_DONE   2
`define SLM_ST_ENV_OVER     3
`define SLM_ST_BITS         4
`endif

// ==== src/slm_pkg.sv ====
// types for the service life maintenance monitor
package slm_pkg;
  typedef logic [13:0] slm_life_t;
  typedef struct packed {
    logic [6:0][15:0] num;
    logic [6:0]       bits;
  } slm_trace_s;
  typedef struct packed {
    logic warn_en;
    logic relay_dis;
    logic pm_alloc;
    logic brake_ctl;
  } slm_cfg_s;
  typedef enum logic [1:0] {SLM_ARMED, SLM_POST, SLM_HELD} slm_trace_e;
endpackage : slm_pkg

// ==== src/slm_trace_buf.sv ====
// alarm trace ring buffer with pre and post trigger window
`timescale 1ns/1ns
`default_nettype none
`include "slm_consts.svh"
module slm_trace_buf (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               sample_en_i,
  input  wire logic               trig_i,
  input  wire logic               inhibit_i,
  input  wire logic               rearm_i,
  input  wire slm_pkg::slm_trace_s sample_i,
  input  wire logic [3:0]         rd_idx_i,
  output slm_pkg::slm_trace_s     rd_data_o,
  output logic                    busy_o,
  output logic                    held_o,
  output logic                    done_o
);
  import slm_pkg::*;
  slm_trace_s mem [`SLM_TRACE_DEPTH];
  slm_trace_e state;
  logic [3:0] wptr;
  logic [3:0] start;
  logic [4:0] post_cnt;

  // buffer keeps running while armed so the pre-trigger part is full once 8 samples have been taken since reset
  always_ff @(posedge clk_i) begin
    if (sample_en_i && state != SLM_HELD) begin
      mem[wptr] <= sample_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= SLM_ARMED;
      wptr     <= 4'h0;
      start    <= 4'h0;
      post_cnt <= 5'h0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (sample_en_i && state != SLM_HELD) begin
        wptr <= wptr + 4'h1;
      end
      case (state)
        SLM_ARMED: begin
          if (trig_i && !inhibit_i) begin
            state    <= SLM_POST;
            post_cnt <= `SLM_TRACE_POST;
          end
        end
        SLM_POST: begin
          // further alarms are ignored here: one recording at a time
          if (sample_en_i) begin
            post_cnt <= post_cnt - 5'h1;
            if (post_cnt == 5'h1) begin
              state  <= SLM_HELD;
              start  <= wptr + 4'h1;
              done_o <= 1'b1;
            end
          end
        end
        SLM_HELD: begin
          if (rearm_i) begin
            state <= SLM_ARMED;
          end
        end
        default: state <= SLM_ARMED;
      endcase
    end
  end

  assign rd_data_o = mem[start + rd_idx_i];
  assign busy_o    = (state == SLM_POST);
  assign held_o    = (state == SLM_HELD);
endmodule : slm_trace_buf
`default_nettype wire

// ==== src/slm_monitor.sv ====
// service life maintenance monitor with classic wishbone register slave
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "slm_consts.svh"
module slm_monitor #(
  parameter int POWERON_CYC = `SLM_POWERON_CYC
) (
  input  wire logic               REF_CLK_I,
  input  wire logic               RESET_I,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  output logic                    IRQ_O,
  input  wire logic               MAIN_POWER_ON_I,
  input  wire logic               SERVO_ON_I,
  input  wire logic               RELAY_OP_I,
  input  wire logic [15:0]        DRIVE_ENV_I,
  input  wire logic [15:0]        MOTOR_ENV_I,
  input  wire logic               ALARM_I,
  input  wire logic               UTIL_BUSY_I,
  input  wire logic               EXT_TRACE_I,
  input  wire slm_pkg::slm_trace_s TRACE_SAMPLE_I,
  output logic                    MAINT_DUE_O,
  output logic                    MAINT_DUE_OE_N_O,
  output logic                    MAINT_WARN_O,
  output logic                    RELAY_ALARM_O
);
  import slm_pkg::*;

  function automatic slm_life_t sat_dec(input slm_life_t v, input slm_life_t step);
    sat_dec = (v > step) ? v - step : 14'd0;
  endfunction : sat_dec

  function automatic logic [31:0] life_word(input slm_life_t v);
    life_word = {18'h0, v};
  endfunction : life_word

  // pin synchronisers: stage 0 feeds stage 1 only
  logic [2:0] pwr_s, srv_s, rly_s;
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pwr_s <= 3'h0;
      srv_s <= 3'h0;
      rly_s <= 3'h0;
    end else begin
      pwr_s <= {pwr_s[1:0], MAIN_POWER_ON_I};
      srv_s <= {srv_s[1:0], SERVO_ON_I};
      rly_s <= {rly_s[1:0], RELAY_OP_I};
    end
  end
  logic pwr_on_ev, servo_off_ev, relay_ev;
  assign pwr_on_ev    = pwr_s[1] & ~pwr_s[2];
  assign servo_off_ev = ~srv_s[1] & srv_s[2];
  assign relay_ev     = rly_s[1] & ~rly_s[2];

  // wishbone decode
  logic wb_req, wr_en, rd_en;
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_en  = wb_req & WB_WE_I & WB_SEL_I[0];
  assign rd_en  = wb_req & ~WB_WE_I;

  // configuration: written value is staged, active copy loads at restart, except pm_alloc, which follows every cycle
  slm_cfg_s cfg_wr, cfg;
  logic     load_pend;
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cfg_wr    <= '0;
      cfg       <= '0;
      load_pend <= 1'b1;
    end else begin
      if (wr_en && WB_ADR_I == `SLM_ADR_CTRL) begin
        cfg_wr <= {WB_DAT_I[`SLM_CTRL_WARN_EN], WB_DAT_I[`SLM_CTRL_RELAY_DIS],
                   WB_DAT_I[`SLM_CTRL_PM_ALLOC], WB_DAT_I[`SLM_CTRL_BRAKE_CTL]};
      end
      // allocation is not a restart-bound setting
      cfg.pm_alloc <= cfg_wr.pm_alloc;
      if (load_pend) begin
        cfg.warn_en   <= cfg_wr.warn_en;
        cfg.relay_dis <= cfg_wr.relay_dis;
        cfg.brake_ctl <= cfg_wr.brake_ctl;
      end
      load_pend <= wr_en && WB_ADR_I == `SLM_ADR_CMD && WB_DAT_I[`SLM_CMD_RESTART];
    end
  end

  logic relay_pred;
  assign relay_pred = cfg.brake_ctl & ~cfg.relay_dis;

  // life figures in 0.01 % units; reset stands in for the unused state
  slm_life_t life_fan, life_cap, life_inr, life_db, life_rly;
  logic [15:0] relay_ops;
  logic [1:0]  relay_sub;
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      life_fan <= `SLM_LIFE_FULL;
      life_cap <= `SLM_LIFE_FULL;
      life_inr <= `SLM_LIFE_FULL;
      life_db  <= `SLM_LIFE_FULL;
    end else if (pwr_on_ev || servo_off_ev) begin
      // both events in one cycle count once; they come from separate pins
      life_fan <= sat_dec(life_fan, `SLM_STEP_FAN);
      life_cap <= sat_dec(life_cap, `SLM_STEP_CAP);
      life_inr <= sat_dec(life_inr, `SLM_STEP_INRUSH);
      life_db  <= sat_dec(life_db, `SLM_STEP_DB);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      life_rly  <= `SLM_LIFE_FULL;
      relay_ops <= 16'h0;
      relay_sub <= 2'h0;
    end else if (relay_ev) begin
      if (relay_ops != 16'hffff) begin
        relay_ops <= relay_ops + 16'h1;
      end
      // three operations per 0.01 % puts 0 % at the alarm limit
      if (relay_sub == `SLM_RELAY_OPS_PER - 2'd1) begin
        relay_sub <= 2'h0;
        life_rly  <= sat_dec(life_rly, 14'd1);
      end else begin
        relay_sub <= relay_sub + 2'h1;
      end
    end
  end

  // environment figures, same clock domain, registered
  logic [15:0] env_drv, env_mot;
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      env_drv <= 16'h0;
      env_mot <= 16'h0;
    end else begin
      env_drv <= DRIVE_ENV_I;
      env_mot <= MOTOR_ENV_I;
    end
  end

  logic due, env_over, relay_alm;
  assign due = life_fan <= `SLM_LIFE_THRESH || life_cap <= `SLM_LIFE_THRESH ||
               life_inr <= `SLM_LIFE_THRESH || life_db <= `SLM_LIFE_THRESH ||
               (relay_pred && life_rly <= `SLM_LIFE_THRESH);
  assign env_over  = env_drv > `SLM_ENV_LIMIT || env_mot > `SLM_ENV_LIMIT;
  assign relay_alm = relay_pred && relay_ops > `SLM_RELAY_OPS_LIMIT;

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      MAINT_DUE_O      <= 1'b0;
      MAINT_DUE_OE_N_O <= 1'b1;
      MAINT_WARN_O     <= 1'b0;
      RELAY_ALARM_O    <= 1'b0;
    end else begin
      MAINT_DUE_O      <= cfg.pm_alloc & due;
      MAINT_DUE_OE_N_O <= ~cfg.pm_alloc;
      MAINT_WARN_O     <= cfg.warn_en & due;
      RELAY_ALARM_O    <= relay_alm;
    end
  end

  // trace sampling divider and power-on inhibit
  logic [7:0]  smp_cnt;
  logic        smp_en;
  logic [31:0] pon_cnt;
  logic        pon_busy;
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      smp_cnt  <= 8'h0;
      smp_en   <= 1'b0;
      pon_cnt  <= 32'h0;
      pon_busy <= 1'b1;
    end else begin
      smp_en  <= smp_cnt == 8'((`SLM_TRACE_CYC) - 1);
      smp_cnt <= (smp_cnt == 8'((`SLM_TRACE_CYC) - 1)) ? 8'h0 : smp_cnt + 8'h1;
      if (pon_busy) begin
        pon_cnt  <= pon_cnt + 32'h1;
        pon_busy <= pon_cnt < 32'(POWERON_CYC - 1);
      end
    end
  end

  logic any_alarm, alarm_q, trace_done, trace_busy, trace_held, rearm;
  logic [3:0] trace_idx;
  slm_trace_s smp, rd_smp;
  assign any_alarm = ALARM_I | RELAY_ALARM_O;
  assign rearm = wr_en && WB_ADR_I == `SLM_ADR_CMD && WB_DAT_I[`SLM_CMD_TRACE_REARM];
  always_comb begin
    smp         = TRACE_SAMPLE_I;
    smp.bits[0] = any_alarm;
  end
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= any_alarm;
    end
  end

  slm_trace_buf u_trace (
    .clk_i       (REF_CLK_I),
    .rst_i       (RESET_I),
    .sample_en_i (smp_en),
    .trig_i      (any_alarm & ~alarm_q),
    .inhibit_i   (pon_busy | UTIL_BUSY_I | EXT_TRACE_I),
    .rearm_i     (rearm),
    .sample_i    (smp),
    .rd_idx_i    (trace_idx),
    .rd_data_o   (rd_smp),
    .busy_o      (trace_busy),
    .held_o      (trace_held),
    .done_o      (trace_done)
  );

  // sticky status; a read clears, but a new event in that cycle wins
  logic [`SLM_ST_BITS-1:0] status, mask, ev, lvl_q;
  logic st_rd;
  assign st_rd = rd_en && WB_ADR_I == `SLM_ADR_STATUS;
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lvl_q <= '0;
    end else begin
      lvl_q <= {env_over, 1'b0, RELAY_ALARM_O, MAINT_WARN_O};
    end
  end
  assign ev = {env_over & ~lvl_q[3], trace_done, RELAY_ALARM_O & ~lvl_q[1],
               MAINT_WARN_O & ~lvl_q[0]};
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      status <= '0;
      mask   <= '0;
      IRQ_O  <= 1'b0;
    end else begin
      status <= (st_rd ? '0 : status) | ev;
      if (wr_en && WB_ADR_I == `SLM_ADR_MASK) begin
        mask <= WB_DAT_I[`SLM_ST_BITS-1:0];
      end
      IRQ_O <= |(status & mask);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trace_idx <= 4'h0;
    end else if (wr_en && WB_ADR_I == `SLM_ADR_TRACE_IDX) begin
      trace_idx <= WB_DAT_I[3:0];
    end
  end

  // read mux; unmapped addresses read zero and are still acknowledged
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    case (WB_ADR_I)
      `SLM_ADR_CTRL:      rd_data = {28'h0, cfg_wr.brake_ctl, cfg_wr.pm_alloc,
                                     cfg_wr.relay_dis, cfg_wr.warn_en};
      `SLM_ADR_STATUS:    rd_data = {28'h0, status};
      `SLM_ADR_MASK:      rd_data = {28'h0, mask};
      8'h10:              rd_data = {16'h0, env_drv};
      8'h14:              rd_data = {16'h0, env_mot};
      8'h18:              rd_data = life_word(life_fan);
      8'h1c:              rd_data = life_word(life_cap);
      8'h20:              rd_data = life_word(life_inr);
      8'h24:              rd_data = life_word(life_db);
      `SLM_ADR_MON_LAST:  rd_data = life_word(life_rly);
      `SLM_ADR_RELAY_OPS: rd_data = {16'h0, relay_ops};
      `SLM_ADR_WARN:      rd_data = {`SLM_RELAY_ALM_CODE, 2'h0, RELAY_ALARM_O, MAINT_WARN_O,
                                     `SLM_WARN_CODE, 3'h0, MAINT_DUE_O};
      `SLM_ADR_TRACE_IDX: rd_data = {28'h0, trace_idx};
      `SLM_ADR_TRACE_STAT:rd_data = {29'h0, pon_busy, trace_busy, trace_held};
      `SLM_ADR_TRACE_BITS:rd_data = {25'h0, rd_smp.bits};
      default: begin
        if (WB_ADR_I >= `SLM_ADR_TRACE_BASE && WB_ADR_I < `SLM_ADR_TRACE_BITS) begin
          rd_data = {16'h0, rd_smp.num[3'(WB_ADR_I[4:2])]};
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= rd_en ? rd_data : 32'h0;
    end
  end
endmodule : slm_monitor
`default_nettype wire

// ==== verification/slm_monitor_checker.sv ====
// port assertions for the service life maintenance monitor
`timescale 1ns/1ns
`default_nettype none
module slm_monitor_checker #(
  parameter int POWERON_CYC = 20
) (
  input wire logic        REF_CLK_I,
  input wire logic        RESET_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        IRQ_O,
  input wire logic        MAINT_DUE_O,
  input wire logic        MAINT_DUE_OE_N_O,
  input wire logic        MAINT_WARN_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  property p_ack_answer; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_unalloc_quiet; MAINT_DUE_OE_N_O |-> !MAINT_DUE_O; endproperty
  a_unalloc_quiet: assert property (p_unalloc_quiet) else $error("due driven while unallocated");
  // lives only fall, so only a register write may take these down again
  // a register write shows on the outputs two edges after its ack, so the ack's echo is excluded too
  property p_due_holds;
    MAINT_DUE_O && !WB_CYC_I && !WB_ACK_O && !$past(WB_ACK_O) |=> MAINT_DUE_O;
  endproperty
  a_due_holds: assert property (p_due_holds) else $error("due output dropped");
  property p_warn_holds;
    MAINT_WARN_O && !WB_CYC_I && !WB_ACK_O && !$past(WB_ACK_O) |=> MAINT_WARN_O;
  endproperty
  a_warn_holds: assert property (p_warn_holds) else $error("warning dropped");
  property p_irq_fall; $fell(IRQ_O) |-> $past(WB_ACK_O) || $past(WB_ACK_O, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt cleared without access");
  c_due: cover property ($rose(MAINT_DUE_O));
  c_warn: cover property ($rose(MAINT_WARN_O));
  c_irq: cover property ($rose(IRQ_O));
endmodule : slm_monitor_checker
`default_nettype wire

// ==== verification/slm_host_model.sv ====
// host controller model sampling the maintenance-due line
`timescale 1ns/1ns
`default_nettype none
module slm_host_model (
  input  wire logic clk_i,
  input  wire logic due_i,
  input  wire logic due_oe_n_i,
  output logic      closed_o
);
  // line has a pull-up, so a released pin always reads open
  always_ff @(posedge clk_i) closed_o <= !due_oe_n_i && due_i;
endmodule : slm_host_model
`default_nettype wire

// ==== verification/slm_monitor_tb_top.sv ====
// testbench for the service life maintenance monitor
`timescale 1ns/1ns
`default_nettype none
module slm_monitor_tb_top;
  import slm_pkg::*;
  localparam int POWERON_CYC = 20;
  logic        clk, rst, cyc, stb, we, ack, irq, due, due_oe_n, warn, relay_alm;
  logic        pwr, servo, relay, alarm, util, ext, closed;
  logic [7:0]  adr;
  logic [31:0] dat_i, dat_o;
  logic [15:0] drive_env, motor_env;
  slm_trace_s  smp;
  logic [31:0] exp_q[$];
  int          fails, num_checks, cycles;
  slm_monitor #(.POWERON_CYC(POWERON_CYC)) uut (
    .REF_CLK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ_O(irq),
    .MAIN_POWER_ON_I(pwr), .SERVO_ON_I(servo), .RELAY_OP_I(relay), .DRIVE_ENV_I(drive_env),
    .MOTOR_ENV_I(motor_env), .ALARM_I(alarm), .UTIL_BUSY_I(util), .EXT_TRACE_I(ext),
    .TRACE_SAMPLE_I(smp), .MAINT_DUE_O(due), .MAINT_DUE_OE_N_O(due_oe_n), .MAINT_WARN_O(warn),
    .RELAY_ALARM_O(relay_alm));
  slm_host_model u_host (.clk_i(clk), .due_i(due), .due_oe_n_i(due_oe_n), .closed_o(closed));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task pin(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : pin
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // one classic cycle; the answer is awaited, never assumed
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    @(posedge clk);
    // only the cycle watchdog ends a wait that never sees ack
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // each period: power-on edge, plus a separate servo-off edge when srv is set
  task ev(input int n, input logic srv);
    repeat (n) begin
      pwr <= 1'b1;
      servo <= srv;
      repeat (3) @(posedge clk);
      pwr <= 1'b0;
      servo <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : ev
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
      num_checks++;
      if (exp_q.size() == 0) begin
        fails++;
        $display("MISMATCH t=%0t seen=%h exp=none", $time, dat_o);
      end else begin
        check(dat_o, exp_q.pop_front());
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    {cyc, stb, we, pwr, servo, relay, alarm, util, ext} = '0;
    adr = '0;
    dat_i = '0;
    rst = 1'b1;
    void'($urandom(80));
    drive_env = 16'($urandom % 101);
    motor_env = 16'($urandom % 101);
    for (int i = 0; i < 7; i++) smp.num[i] = 16'h1000 + 16'(i);
    smp.bits = 7'h54;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pin(due_oe_n, 1'b1);
    // alarm raised inside the power-on window must leave the trace armed
    alarm <= 1'b1;
    rd(8'h38, 32'h4);
    for (int a = 'h18; a <= 'h28; a += 4) rd(8'(a), 32'd10000);
    rd(8'h10, {16'h0, drive_env});
    rd(8'h14, {16'h0, motor_env});
    wr(8'hfc, $urandom);
    rd(8'hfc, 32'h0);
    wr(8'h00, 32'hc);
    wr(8'h04, 32'h1);
    repeat (3) @(posedge clk);
    pin(due_oe_n, 1'b0);
    rd(8'h38, 32'h0);
    alarm <= 1'b0;
    $display("test config done");
    wr(8'h0c, 32'h0);
    drive_env <= 16'd150;
    repeat (5) @(posedge clk);
    pin(irq, 1'b0);
    rd(8'h08, 32'h8);
    wr(8'h0c, 32'h8);
    drive_env <= 16'd50;
    repeat (3) @(posedge clk);
    drive_env <= 16'd150;
    repeat (5) @(posedge clk);
    pin(irq, 1'b1);
    rd(8'h08, 32'h8);
    repeat (2) @(posedge clk);
    pin(irq, 1'b0);
    $display("test interrupt done");
    util <= 1'b1;
    alarm <= 1'b1;
    repeat (5) @(posedge clk);
    rd(8'h38, 32'h0);
    util <= 1'b0;
    alarm <= 1'b0;
    // long quiet spell so the pre-alarm half of the buffer is filled
    repeat (500) @(posedge clk);
    alarm <= 1'b1;
    repeat (500) @(posedge clk);
    rd(8'h38, 32'h1);
    rd(8'h08, 32'h4);
    wr(8'h34, 32'hf);
    for (int c = 0; c < 7; c++) rd(8'h40 + 8'(4 * c), 32'h1000 + 32'(c));
    rd(8'h5c, 32'h55);
    wr(8'h34, 32'h0);
    rd(8'h5c, 32'h54);
    wr(8'h04, 32'h2);
    alarm <= 1'b0;
    ext <= 1'b1;
    repeat (3) @(posedge clk);
    alarm <= 1'b1;
    repeat (5) @(posedge clk);
    rd(8'h38, 32'h0);
    {alarm, ext} <= 2'b00;
    $display("test trace done");
    repeat (5) begin
      relay <= 1'b1;
      repeat (3) @(posedge clk);
      relay <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd(8'h2c, 32'd5);
    rd(8'h28, 32'd9999);
    pin(relay_alm, 1'b0);
    $display("test relay done");
    ev(4499, 1'b1);
    ev(1, 1'b0);
    rd(8'h18, 32'd1001);
    pin(closed, 1'b0);
    ev(1, 1'b0);
    pin(closed, 1'b1);
    pin(warn, 1'b0);
    wr(8'h00, 32'hd);
    repeat (4) @(posedge clk);
    pin(warn, 1'b0);
    wr(8'h04, 32'h1);
    repeat (4) @(posedge clk);
    pin(warn, 1'b1);
    rd(8'h30, 32'h23219b01);
    rd(8'h08, 32'h1);
    ev(510, 1'b1);
    for (int a = 'h18; a <= 'h24; a += 4) rd(8'(a), 32'h0);
    $display("test life done");
    report_and_stop();
  end
endmodule : slm_monitor_tb_top
bind slm_monitor slm_monitor_checker #(.POWERON_CYC(POWERON_CYC)) u_chk (
  .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ_O(IRQ_O), .MAINT_DUE_O(MAINT_DUE_O),
  .MAINT_DUE_OE_N_O(MAINT_DUE_OE_N_O), .MAINT_WARN_O(MAINT_WARN_O));
`default_nettype wire
